// *** verilog/tpg_map.svh ***
// Offsets, field masks and reset values of the two port GPIO block
// Overview of operation
// - Direction one makes second port pin output
// - Output pin drives the latch value
// - Latch write updates latch and driven pin
// - Latch read returns latch for output pins
// - Direction zero makes pin input, driver off
// - Input pin: latch stores write, not driven
// - Input pin read: pin, RMW read: latch
// - Pin read regardless of peripheral input use
// - Reset clears second port direction bits
// - Reset clears first port direction bits
// - Standby with select high: Hi-Z, input low
// - Standby with select low: state held
// - Pull-up select one connects pull-up
// - Low output disconnects pull-up always
// - Second port implements bits two and one
// - First port input: pin read, RMW latch
`ifndef TPG_MAP_SVH
`define TPG_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define TPG_OFS_F_LATCH 8'h00
`define TPG_OFS_F_DIR 8'h04
`define TPG_OFS_G_LATCH 8'h08
`define TPG_OFS_G_DIR 8'h0C
`define TPG_OFS_G_PULL 8'h10
`define TPG_OFS_F_LATCH_RMW 8'h20
`define TPG_OFS_G_LATCH_RMW 8'h28

// ****************************************
// Implemented bits and reset values
// ****************************************
`define TPG_F_MASK 8'h03
`define TPG_G_MASK 8'h06
`define TPG_RST_LATCH 8'h00
`define TPG_RST_DIR 8'h00
`define TPG_RST_PULL 8'h00

`endif

// *** verilog/tpg_pkg.sv ***
// Types shared by the two port GPIO block
package tpg_pkg;
    typedef logic [7:0] tpg_byte_t;
    typedef enum logic [0:0]
    {
        TPG_BUS_IDLE = 1'b0,
        TPG_BUS_ACK = 1'b1
    } tpg_bus_e;
endpackage

// *** verilog/tpg_reg.sv ***
// Masked 8-bit control register with write enable
`timescale 1ns/100ps
module tpg_reg
    import tpg_pkg::*;
#(
    parameter tpg_byte_t MASK = 8'hFF,
    parameter tpg_byte_t RESET = 8'h00
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Write side
    input wire logic we,
    input wire tpg_byte_t wdata,
    // Stored value
    output tpg_byte_t q
);
    generate
        if (MASK == 8'h00)
        begin : g_chk
            $error("tpg_reg needs at least one implemented bit");
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= RESET & MASK;
        else if (we)
            q <= wdata & MASK;
    end
endmodule

// *** verilog/tpg_pin.sv ***
// One port pin: drive, output enable, pull-up and input sampling
`timescale 1ns/100ps
module tpg_pin
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control from registers
    input wire logic dir,
    input wire logic latch,
    input wire logic pull_sel,
    // Standby state
    input wire logic standby,
    input wire logic hiz,
    // Pad side
    input wire logic pad_in,
    output logic pad_out_q,
    output logic pad_oe_q,
    output logic pull_en_q,
    output logic in_q
);
    logic oe_d;
    logic out_d;

    always_comb
    begin
        oe_d = pad_oe_q;
        out_d = pad_out_q;
        if (standby && hiz)
            oe_d = 1'b0;
        else if (!standby)
        begin
            oe_d = dir;
            out_d = latch;
        end
    end

    // Drive and enable, frozen in standby with select low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pad_oe_q <= 1'b0;
            pad_out_q <= 1'b0;
        end
        else
        begin
            pad_oe_q <= oe_d;
            pad_out_q <= out_d;
        end
    end

    // Pull-up, cut while driving low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pull_en_q <= 1'b0;
        else
            pull_en_q <= pull_sel && !(oe_d && !out_d);
    end

    // Input sample, gated low in Hi-Z standby
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            in_q <= 1'b0;
        else
            in_q <= (standby && hiz) ? 1'b0 : pad_in;
    end
endmodule

// *** verilog/tpg_top.sv ***
// Two port GPIO block with APB register slave
`timescale 1ns/100ps
`include "tpg_map.svh"
module tpg_top
    import tpg_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB request
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    // APB answer
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Standby controller
    input wire logic standby_stop_watch,
    input wire logic standby_pin_hiz_select,
    // First port pins
    input wire logic [1:0] pf_in,
    output logic [1:0] pf_out,
    output logic [1:0] pf_oe,
    output logic [1:0] pf_in_gated,
    // Second port pins
    input wire logic [2:1] pg_in,
    output logic [2:1] pg_out,
    output logic [2:1] pg_oe,
    output logic [2:1] pg_pullup_en,
    output logic [2:1] pg_in_gated
);
    generate
        if (ADDR_W < 8)
        begin : g_chk
            $error("tpg_top needs ADDR_W of at least 8");
        end
    endgenerate

    // ****************************************
    // Bus handshake and decode
    // ****************************************
    tpg_bus_e bus_q;
    logic [31:0] prdata_d;
    logic hit_d;
    logic wr_go;
    logic wr_f_latch;
    logic wr_f_dir;
    logic wr_g_latch;
    logic wr_g_dir;
    logic wr_g_pull;
    logic [7:0] ofs;
    logic hi_zero;
    tpg_byte_t f_latch_q;
    tpg_byte_t f_dir_q;
    tpg_byte_t g_latch_q;
    tpg_byte_t g_dir_q;
    tpg_byte_t g_pull_q;
    tpg_byte_t f_pin_q;
    tpg_byte_t g_pin_q;
    tpg_byte_t f_read;
    tpg_byte_t g_read;

    assign ofs = paddr[7:0];
    assign hi_zero = (paddr >> 8) == '0;
    assign wr_go = psel && penable && pwrite && pready;
    assign wr_f_latch = wr_go && hi_zero && ofs == `TPG_OFS_F_LATCH;
    assign wr_f_dir = wr_go && hi_zero && ofs == `TPG_OFS_F_DIR;
    assign wr_g_latch = wr_go && hi_zero && ofs == `TPG_OFS_G_LATCH;
    assign wr_g_dir = wr_go && hi_zero && ofs == `TPG_OFS_G_DIR;
    assign wr_g_pull = wr_go && hi_zero && ofs == `TPG_OFS_G_PULL;

    // Normal read: latch for outputs, pin level for inputs
    assign g_read = (g_dir_q & g_latch_q) | (~g_dir_q & g_pin_q);
    assign f_read = (f_dir_q & f_latch_q) | (~f_dir_q & f_pin_q);

    always_comb
    begin
        prdata_d = 32'h0000_0000;
        hit_d = hi_zero;
        case (ofs)
            `TPG_OFS_F_LATCH: prdata_d[7:0] = f_read;
            `TPG_OFS_F_DIR: prdata_d[7:0] = f_dir_q;
            `TPG_OFS_G_LATCH: prdata_d[7:0] = g_read;
            `TPG_OFS_G_DIR: prdata_d[7:0] = g_dir_q;
            `TPG_OFS_G_PULL: prdata_d[7:0] = g_pull_q;
            `TPG_OFS_F_LATCH_RMW: prdata_d[7:0] = f_latch_q;
            `TPG_OFS_G_LATCH_RMW: prdata_d[7:0] = g_latch_q;
            default: hit_d = 1'b0;
        endcase
        if (!hit_d)
            prdata_d = 32'h0000_0000;
    end

    // One wait state, then a one-cycle ready
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bus_q <= TPG_BUS_IDLE;
        else
        begin
            case (bus_q)
                TPG_BUS_IDLE: bus_q <= (psel && penable) ? TPG_BUS_ACK : TPG_BUS_IDLE;
                TPG_BUS_ACK: bus_q <= TPG_BUS_IDLE;
                default: bus_q <= TPG_BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (bus_q == TPG_BUS_IDLE && psel && penable)
        begin
            pready <= 1'b1;
            pslverr <= !hit_d;
            prdata <= pwrite ? 32'h0000_0000 : prdata_d;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ****************************************
    // Port registers
    // ****************************************
    tpg_reg #(.MASK(`TPG_F_MASK), .RESET(`TPG_RST_LATCH)) u_f_latch
    (
        .pclk(pclk),
        .presetn(presetn),
        .we(wr_f_latch),
        .wdata(pwdata[7:0]),
        .q(f_latch_q)
    );

    tpg_reg #(.MASK(`TPG_F_MASK), .RESET(`TPG_RST_DIR)) u_f_dir
    (
        .pclk(pclk),
        .presetn(presetn),
        .we(wr_f_dir),
        .wdata(pwdata[7:0]),
        .q(f_dir_q)
    );

    tpg_reg #(.MASK(`TPG_G_MASK), .RESET(`TPG_RST_LATCH)) u_g_latch
    (
        .pclk(pclk),
        .presetn(presetn),
        .we(wr_g_latch),
        .wdata(pwdata[7:0]),
        .q(g_latch_q)
    );

    tpg_reg #(.MASK(`TPG_G_MASK), .RESET(`TPG_RST_DIR)) u_g_dir
    (
        .pclk(pclk),
        .presetn(presetn),
        .we(wr_g_dir),
        .wdata(pwdata[7:0]),
        .q(g_dir_q)
    );

    tpg_reg #(.MASK(`TPG_G_MASK), .RESET(`TPG_RST_PULL)) u_g_pull
    (
        .pclk(pclk),
        .presetn(presetn),
        .we(wr_g_pull),
        .wdata(pwdata[7:0]),
        .q(g_pull_q)
    );

    // ****************************************
    // Pin cells
    // ****************************************
    assign f_pin_q[7:2] = 6'h00;
    assign g_pin_q[7:3] = 5'h00;
    assign g_pin_q[0] = 1'b0;
    assign pf_in_gated = f_pin_q[1:0];
    assign pg_in_gated = g_pin_q[2:1];

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1)
        begin : g_f
            tpg_pin u_pin
            (
                .pclk(pclk),
                .presetn(presetn),
                .dir(f_dir_q[i]),
                .latch(f_latch_q[i]),
                .pull_sel(1'b0),
                .standby(standby_stop_watch),
                .hiz(standby_pin_hiz_select),
                .pad_in(pf_in[i]),
                .pad_out_q(pf_out[i]),
                .pad_oe_q(pf_oe[i]),
                .pull_en_q(),
                .in_q(f_pin_q[i])
            );
        end
        for (i = 1; i < 3; i = i + 1)
        begin : g_g
            tpg_pin u_pin
            (
                .pclk(pclk),
                .presetn(presetn),
                .dir(g_dir_q[i]),
                .latch(g_latch_q[i]),
                .pull_sel(g_pull_q[i]),
                .standby(standby_stop_watch),
                .hiz(standby_pin_hiz_select),
                .pad_in(pg_in[i]),
                .pad_out_q(pg_out[i]),
                .pad_oe_q(pg_oe[i]),
                .pull_en_q(pg_pullup_en[i]),
                .in_q(g_pin_q[i])
            );
        end
    endgenerate

    // ****************************************
    // Checks
    // ****************************************
    logic rd_done;
    logic sw_hiz;
    logic sw_hold;
    assign rd_done = psel && penable && !pwrite && pready && hi_zero;
    assign sw_hiz = standby_stop_watch && standby_pin_hiz_select;
    assign sw_hold = standby_stop_watch && !standby_pin_hiz_select;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_g_out_follow: assert property ($past(!standby_stop_watch) |->
        pg_out == $past(g_latch_q[2:1]) && pg_oe == $past(g_dir_q[2:1]))
        else $error("second port pins do not follow latch and direction");
    a_g_write_drive: assert property (
        (wr_g_latch && g_dir_q[2:1] == 2'b11 && !standby_stop_watch) ##1 !standby_stop_watch
        |-> ##1 pg_out == $past(pwdata[2:1], 2) && pg_oe == 2'b11)
        else $error("written latch value not driven two cycles later");
    a_g_input_off: assert property ($past(!standby_stop_watch) |->
        (pg_oe & ~$past(g_dir_q[2:1])) == 2'b00)
        else $error("input pin has its driver enabled");
    a_g_read_mux: assert property (
        (rd_done && ofs == `TPG_OFS_G_LATCH) |-> prdata[2:1] == $past(
        (g_dir_q[2:1] & g_latch_q[2:1]) | (~g_dir_q[2:1] & g_pin_q[2:1])))
        else $error("normal read of second port data wrong");
    a_rmw_latch: assert property (
        (rd_done && ofs == `TPG_OFS_G_LATCH_RMW) |-> prdata[7:0] == $past(g_latch_q))
        else $error("read-modify-write view does not return latch");
    a_f_read_mux: assert property (
        (rd_done && ofs == `TPG_OFS_F_LATCH) |-> prdata[1:0] == $past(
        (f_dir_q[1:0] & f_latch_q[1:0]) | (~f_dir_q[1:0] & f_pin_q[1:0])))
        else $error("normal read of first port data wrong");
    a_f_out_follow: assert property ($past(!standby_stop_watch) |->
        pf_oe == $past(f_dir_q[1:0]) && pf_out == $past(f_latch_q[1:0]))
        else $error("first port pins do not follow latch and direction");
    a_reset_dir: assert property (@(posedge pclk) disable iff (1'b0)
        !presetn |-> g_dir_q == 8'h00 && f_dir_q == 8'h00 && pg_oe == 2'b00 && pf_oe == 2'b00)
        else $error("direction not cleared by reset");
    a_hiz_standby: assert property ($past(sw_hiz) |->
        pg_oe == 2'b00 && pf_oe == 2'b00 && pg_in_gated == 2'b00 && pf_in_gated == 2'b00)
        else $error("standby Hi-Z or input gating not applied");
    a_hold_standby: assert property (sw_hold |=>
        $stable(pg_out) && $stable(pg_oe) && $stable(pf_out) && $stable(pf_oe))
        else $error("pin state changed in holding standby");
    a_pull_low_cut: assert property ((pg_pullup_en & pg_oe & ~pg_out) == 2'b00)
        else $error("pull-up left on while driving low");
    a_pull_select: assert property (
        (pg_pullup_en & ~$past(g_pull_q[2:1])) == 2'b00)
        else $error("pull-up on without select bit");
    a_unused_bits: assert property (((g_latch_q | g_dir_q | g_pull_q) & ~`TPG_G_MASK) == 8'h00)
        else $error("unimplemented second port bits set");

    c_g_write: cover property (wr_g_latch && g_dir_q[2:1] != 2'b00);
    c_rmw_read: cover property (rd_done && ofs == `TPG_OFS_G_LATCH_RMW);
    c_hiz_entry: cover property (!standby_stop_watch ##1 sw_hiz);
    c_hold_entry: cover property (!standby_stop_watch ##1 sw_hold [*2]);
endmodule

// *** sim/tpg_pad_model.sv ***
// Board side of the port pins: drivers, pull-up and floating pads
`timescale 1ns/100ps
module tpg_pad_model
#(
    parameter int W = 2
)
(
    // Clock
    input wire logic pclk,
    // Device pin side
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] pull_en,
    // External driver on the board
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    // Resolved pad level
    output logic [W-1:0] pad
);
    logic [W-1:0] float_q = '0;

    // Undriven pads wander every cycle
    always @(posedge pclk)
    begin
        float_q <= ~float_q;
    end

    // No shared peripheral output drives the pads
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            if (oe[i])
                pad[i] = out[i];
            else if (ext_en[i])
                pad[i] = ext_val[i];
            else if (pull_en[i])
                pad[i] = 1'b1;
            else
                pad[i] = float_q[i];
        end
    end
endmodule

// *** sim/tpg_top_tb.sv ***
// Register and pin level testbench of the two port GPIO block
`timescale 1ns/100ps
`include "tpg_map.svh"
module tpg_top_tb;
    import tpg_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic stby = 1'b0;
    logic hiz_sel = 1'b0;
    logic [1:0] pf_in, pf_out, pf_oe, pf_in_gated;
    logic [2:1] pg_in, pg_out, pg_oe, pg_pullup_en, pg_in_gated;
    logic [1:0] f_ext_en = 2'h0, f_ext_val = 2'h0, g_ext_en = 2'h0, g_ext_val = 2'h0;
    int n_fail = 0;
    int samples_checked = 0;

    always #4 pclk = ~pclk;

    tpg_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .standby_stop_watch(stby),
        .standby_pin_hiz_select(hiz_sel), .pf_in(pf_in), .pf_out(pf_out),
        .pf_oe(pf_oe), .pf_in_gated(pf_in_gated), .pg_in(pg_in), .pg_out(pg_out),
        .pg_oe(pg_oe), .pg_pullup_en(pg_pullup_en), .pg_in_gated(pg_in_gated));
    tpg_pad_model #(.W(2)) pad_f (.pclk(pclk), .oe(pf_oe), .out(pf_out),
        .pull_en(2'h0), .ext_en(f_ext_en), .ext_val(f_ext_val), .pad(pf_in));
    tpg_pad_model #(.W(2)) pad_g (.pclk(pclk), .oe(pg_oe), .out(pg_out),
        .pull_en(pg_pullup_en), .ext_en(g_ext_en), .ext_val(g_ext_val), .pad(pg_in));

    // ****************************************
    // Report and checks
    // ****************************************
    task print_verdict;
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // ****************************************
    // APB master
    // ****************************************
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int i;
        i = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1)
        begin
            n_fail++;
            $display("[FAIL] %0t no pready", $time);
            print_verdict();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
        chk({31'h0, e}, 32'h0, "write error flag");
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp, "read data");
        chk({31'h0, e}, {31'h0, exp_err}, "read error flag");
    endtask

    // Let register and pad pipeline settle
    task settle;
        repeat (4) @(posedge pclk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`TPG_OFS_F_DIR, 32'h0, 1'b0);
        rd(`TPG_OFS_G_DIR, 32'h0, 1'b0);
        chk({28'h0, pf_oe, pg_oe}, 32'h0, "oe after reset");
        wr(`TPG_OFS_G_DIR, 8'hFF);
        rd(`TPG_OFS_G_DIR, 32'h06, 1'b0);
        wr(`TPG_OFS_G_LATCH, 8'h04);
        settle();
        chk({28'h0, pg_oe, pg_out}, 32'hE, "g output drive");
        rd(`TPG_OFS_G_LATCH, 32'h04, 1'b0);
        wr(`TPG_OFS_G_LATCH, 8'h02);
        settle();
        chk({30'h0, pg_out}, 32'h1, "g new latch value");
        // Mixed: pin one output, pin two input pulled low externally
        g_ext_en <= 2'b10;
        g_ext_val <= 2'b00;
        wr(`TPG_OFS_G_DIR, 8'h02);
        wr(`TPG_OFS_G_LATCH, 8'h06);
        settle();
        chk({30'h0, pg_oe}, 32'h1, "g input pin driver");
        rd(`TPG_OFS_G_LATCH, 32'h02, 1'b0);
        rd(`TPG_OFS_G_LATCH_RMW, 32'h06, 1'b0);
        // Pull-up follows select, cut on low output
        wr(`TPG_OFS_G_PULL, 8'h06);
        wr(`TPG_OFS_G_DIR, 8'h06);
        wr(`TPG_OFS_G_LATCH, 8'h02);
        g_ext_en <= 2'b00;
        settle();
        chk({30'h0, pg_pullup_en}, 32'h1, "pull-up on low out");
        wr(`TPG_OFS_G_DIR, 8'h00);
        settle();
        chk({30'h0, pg_pullup_en}, 32'h3, "pull-up inputs");
        rd(`TPG_OFS_G_LATCH, 32'h06, 1'b0);
        wr(`TPG_OFS_G_PULL, 8'h00);
        settle();
        chk({30'h0, pg_pullup_en}, 32'h0, "pull-up off");
        // First port: pin zero output, pin one input
        f_ext_en <= 2'b10;
        f_ext_val <= 2'b00;
        wr(`TPG_OFS_F_DIR, 8'h01);
        wr(`TPG_OFS_F_LATCH, 8'h03);
        settle();
        chk({28'h0, pf_oe, pf_out}, 32'h7, "f drive");
        rd(`TPG_OFS_F_LATCH, 32'h01, 1'b0);
        rd(`TPG_OFS_F_LATCH_RMW, 32'h03, 1'b0);
        rd(8'h14, 32'h0, 1'b1);
        // Standby holding state
        wr(`TPG_OFS_G_DIR, 8'h06);
        settle();
        stby <= 1'b1;
        wr(`TPG_OFS_G_LATCH, 8'h04);
        wr(`TPG_OFS_F_DIR, 8'h00);
        settle();
        chk({24'h0, pf_oe, pf_out, pg_oe, pg_out}, 32'h7D, "held in standby");
        // Standby high impedance with inputs gated low
        f_ext_en <= 2'b11;
        f_ext_val <= 2'b11;
        g_ext_en <= 2'b11;
        g_ext_val <= 2'b11;
        hiz_sel <= 1'b1;
        settle();
        chk({24'h0, pf_oe, pf_in_gated, pg_oe, pg_in_gated}, 32'h0, "hiz");
        stby <= 1'b0;
        hiz_sel <= 1'b0;
        g_ext_en <= 2'b00;
        settle();
        chk({28'h0, pg_oe, pg_out}, 32'hE, "resume");
        chk({30'h0, pf_in_gated}, 32'h3, "f input sampling");
        // Second reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`TPG_OFS_G_DIR, 32'h0, 1'b0);
        chk({30'h0, pg_oe}, 32'h0, "oe after second reset");
        print_verdict();
    end
endmodule
